// ---- logic/frc_pkg.sv ----
// Package with register map, field layout and types of the round and convert slice.
package frc_pkg;

  // Register byte offsets on the APB window.
  localparam logic [7:0] FRC_CTRL_OFS    = 8'h00;
  localparam logic [7:0] FRC_SRC_LO_OFS  = 8'h04;
  localparam logic [7:0] FRC_SRC_HI_OFS  = 8'h08;
  localparam logic [7:0] FRC_FSTAT_OFS   = 8'h0c;
  localparam logic [7:0] FRC_DST_LO_OFS  = 8'h10;
  localparam logic [7:0] FRC_DST_HI_OFS  = 8'h14;
  localparam logic [7:0] FRC_CR1_OFS     = 8'h18;
  localparam logic [7:0] FRC_IRQ_ST_OFS  = 8'h1c;
  localparam logic [7:0] FRC_IRQ_MSK_OFS = 8'h20;
  localparam logic [7:0] FRC_STATUS_OFS  = 8'h24;

  // Control register field positions.
  localparam int FRC_CTRL_START_POS  = 0;
  localparam int FRC_CTRL_OP_POS     = 1;
  localparam int FRC_CTRL_RECORD_POS = 3;

  // Interrupt status bit positions.
  localparam int FRC_IRQ_DONE_POS    = 0;
  localparam int FRC_IRQ_INVALID_POS = 1;
  localparam int FRC_IRQ_INEXACT_POS = 2;
  localparam int FRC_IRQ_W           = 3;

  // Reset values.
  localparam logic [63:0] FRC_SRC_RST   = 64'h0;
  localparam logic [17:0] FRC_FSTAT_RST = 18'h0;
  localparam logic [3:0]  FRC_CR1_RST   = 4'h0;

  // Number format constants.
  localparam logic [11:0] FRC_DBL_BIAS   = 12'h3ff;
  localparam logic [11:0] FRC_SGL_EMAX   = 12'h07f;
  localparam logic [11:0] FRC_SGL_EMIN   = 12'hf82;
  localparam logic [11:0] FRC_INT_EMAX   = 12'h03f;
  localparam logic [11:0] FRC_INT_EMIN   = 12'hfc0;
  localparam logic [31:0] FRC_INT_MAXPOS = 32'h7fffffff;
  localparam logic [31:0] FRC_INT_MAXNEG = 32'h80000000;
  localparam logic [63:0] FRC_SGL_MAXMAG = 64'h47efffffe0000000;

  // Result class codes of the result_class_flags field.
  localparam logic [4:0] FRC_CLS_QNAN  = 5'h11;
  localparam logic [4:0] FRC_CLS_NINF  = 5'h09;
  localparam logic [4:0] FRC_CLS_NNORM = 5'h08;
  localparam logic [4:0] FRC_CLS_NZERO = 5'h12;
  localparam logic [4:0] FRC_CLS_PZERO = 5'h02;
  localparam logic [4:0] FRC_CLS_PNORM = 5'h04;
  localparam logic [4:0] FRC_CLS_PINF  = 5'h05;

  // Operations and rounding modes.
  typedef enum logic [1:0] {FRC_OP_RSP = 2'h0, FRC_OP_CTIW = 2'h1, FRC_OP_CTIWZ = 2'h2} frc_op_t;
  typedef enum logic [1:0] {FRC_RM_NEAR = 2'h0, FRC_RM_ZERO = 2'h1, FRC_RM_PINF = 2'h2,
                            FRC_RM_NINF = 2'h3} frc_rm_t;

  // Floating-point status/control register layout, low bit last.
  typedef struct packed {
    logic       fx;
    logic       fex;
    logic       vx;
    logic       vxcvi;
    logic       vxsnan;
    logic       xx;
    logic       ux;
    logic       ox;
    logic [4:0] result_class_flags;
    logic       fraction_inexact_bit;
    logic       fraction_rounded_bit;
    logic       invalid_op_enable;
    logic [1:0] rounding_mode_field;
  } frc_fstat_t;

  // Datapath answer for one operation.
  typedef struct packed {
    logic [63:0] fp_dest_reg;
    logic [4:0]  cls;
    logic        rounded;
    logic        inexact;
    logic        snan;
    logic        cvt_invalid;
    logic        ovf;
    logic        unf;
  } frc_res_t;

endpackage

// ---- logic/frc_datapath.sv ----
// Combinational round-to-single and convert-to-word datapath.
`timescale 1ns/10ps
module frc_datapath
  import frc_pkg::*;
(
  input  wire logic [63:0] fp_source_reg, // Double-precision source operand.
  input  wire frc_op_t     op,            // Operation to perform.
  input  wire frc_rm_t     rounding_mode, // Programmable rounding mode.
  output frc_res_t         res            // Result and status.
);

  logic        sgn;
  logic [10:0] bexp;
  logic [51:0] frac;
  logic        is_nan;
  logic        is_inf;
  logic        is_zero;
  logic [11:0] uexp;
  logic [127:0] fixd;
  logic [64:0] mag;
  logic        g;
  logic        s;
  logic        inc;
  logic        sat;
  logic [31:0] iword;
  logic [23:0] sfrac;
  logic [11:0] sexp;
  frc_rm_t     rm;

  assign sgn     = fp_source_reg[63];
  assign bexp    = fp_source_reg[62:52];
  assign frac    = fp_source_reg[51:0];
  assign is_nan  = (&bexp) && (|frac);
  assign is_inf  = (&bexp) && !(|frac);
  assign is_zero = (bexp == 11'h0);
  assign uexp    = {1'b0, bexp} - FRC_DBL_BIAS;

  // Increment decision shared by both operations; zero denormals are treated as zero.
  function automatic logic round_up(input frc_rm_t m, input logic sg, input logic lsb,
                                    input logic gd, input logic st);
    logic r;
    r = 1'b0;
    unique case (m)
      FRC_RM_NEAR: r = gd & (st | lsb);
      FRC_RM_ZERO: r = 1'b0;
      FRC_RM_PINF: r = !sg & (gd | st);
      FRC_RM_NINF: r = sg & (gd | st);
    endcase
    return r;
  endfunction

  always_comb begin
    res   = '0;
    rm    = (op == FRC_OP_CTIWZ) ? FRC_RM_ZERO : rounding_mode;
    fixd  = '0;
    mag   = '0;
    g     = 1'b0;
    s     = 1'b0;
    inc   = 1'b0;
    sat   = 1'b0;
    iword = '0;
    sfrac = '0;
    sexp  = '0;
    if (op == FRC_OP_RSP) begin
      if (is_nan) begin
        // Signalling operands are quieted; the class is quiet NaN.
        res.snan        = !frac[51];
        res.fp_dest_reg = {fp_source_reg[63:52], 1'b1, frac[50:0]};
        res.cls         = FRC_CLS_QNAN;
      end else if (is_inf || is_zero) begin
        res.fp_dest_reg = fp_source_reg;
        res.cls = is_zero ? (sgn ? FRC_CLS_NZERO : FRC_CLS_PZERO) : (sgn ? FRC_CLS_NINF : FRC_CLS_PINF);
      end else if ($signed(uexp) < $signed(FRC_SGL_EMIN)) begin
        // Single denormals are flushed to signed zero to keep the rounder small.
        res.fp_dest_reg = {sgn, 63'h0};
        res.cls         = sgn ? FRC_CLS_NZERO : FRC_CLS_PZERO;
        res.unf         = 1'b1;
        res.inexact     = 1'b1;
      end else begin
        g     = frac[28];
        s     = |frac[27:0];
        inc   = round_up(rm, sgn, frac[29], g, s);
        sfrac = {1'b0, frac[51:29]} + {23'h0, inc};
        sexp  = uexp + {11'h0, sfrac[23]};
        res.rounded = inc;
        res.inexact = g | s;
        if ($signed(sexp) > $signed(FRC_SGL_EMAX)) begin
          res.ovf     = 1'b1;
          res.inexact = 1'b1;
          if (rm == FRC_RM_ZERO || (rm == FRC_RM_PINF && sgn) || (rm == FRC_RM_NINF && !sgn)) begin
            res.fp_dest_reg = {sgn, FRC_SGL_MAXMAG[62:0]};
            res.cls         = sgn ? FRC_CLS_NNORM : FRC_CLS_PNORM;
          end else begin
            res.fp_dest_reg = {sgn, 11'h7ff, 52'h0};
            res.cls         = sgn ? FRC_CLS_NINF : FRC_CLS_PINF;
          end
        end else begin
          // Exact operands come out bit for bit unchanged.
          res.fp_dest_reg = {sgn, sexp[10:0] + 11'h0, sfrac[22:0], 29'h0};
          res.fp_dest_reg[62:52] = sexp[10:0] + bexp - uexp[10:0];
          res.cls         = sgn ? FRC_CLS_NNORM : FRC_CLS_PNORM;
        end
      end
    end else begin
      if (is_nan || is_inf || $signed(uexp) > $signed(FRC_INT_EMAX)) begin
        sat = 1'b1;
      end else if (!is_zero && $signed(uexp) >= $signed(FRC_INT_EMIN)) begin
        // Seven-bit wrap of 63 minus the exponent covers -64..63 without a sign test.
        fixd = {1'b1, frac, 75'h0} >> (7'd63 - uexp[6:0]);
        g    = fixd[63];
        s    = |fixd[62:0];
      end else begin
        s = !is_zero;
      end
      inc = round_up(rm, sgn, fixd[64], g, s);
      mag = {1'b0, fixd[127:64]} + {64'h0, inc};
      if (!sgn && mag > {33'h0, FRC_INT_MAXPOS}) begin
        sat = 1'b1;
      end
      if (sgn && mag > {33'h0, FRC_INT_MAXNEG}) begin
        sat = 1'b1;
      end
      iword = sgn ? 32'(-mag[31:0]) : mag[31:0];
      if (sat) begin
        iword = (sgn && !is_nan) ? FRC_INT_MAXNEG : FRC_INT_MAXPOS;
      end
      res.fp_dest_reg = {32'h0, iword};
      res.cvt_invalid = sat;
      res.snan        = is_nan && !frac[51];
      res.rounded     = inc && !sat;
      res.inexact     = (g | s) && !sat;
    end
  end

endmodule

// ---- logic/frc_top.sv ----
// APB-reached round-to-single and convert-to-word slice with status, condition field and interrupt.
//
// Operation
// - Exact in-range operand copied unchanged.
// - Otherwise round to single using mode field.
// - Round sets class flags unless trapped invalid.
// - Convert word under mode, low word result.
// - Too large saturates to maximum positive.
// - Too small saturates to most negative.
// - Convert leaves class flags free.
// - Convert sets rounded and inexact bits.
// - Truncating convert always rounds toward zero.
// - Record form alone updates condition field.
`timescale 1ns/10ps
module frc_top
  import frc_pkg::*;
(
  input  wire logic        pclk,     // Core clock.
  input  wire logic        presetn,  // Asynchronous reset, active low.
  input  wire logic        psel,     // APB select.
  input  wire logic        penable,  // APB enable.
  input  wire logic        pwrite,   // APB direction, high for write.
  input  wire logic [7:0]  paddr,    // APB byte address.
  input  wire logic [31:0] pwdata,   // APB write data.
  output logic      [31:0] prdata,   // APB read data.
  output logic             pready,   // APB ready.
  output logic             pslverr,  // APB error for unmapped address.
  output logic             irq       // Level interrupt.
);

  // Execution sequence, Gray coded along idle, exec, done.
  typedef enum logic [1:0] {
    FRC_ST_IDLE = 2'b00,
    FRC_ST_EXEC = 2'b01,
    FRC_ST_DONE = 2'b11
  } frc_state_t;

  frc_state_t  state_ff;
  frc_state_t  nxt_state;
  logic [63:0] src_ff;
  logic [63:0] nxt_src;
  logic [63:0] dst_ff;
  logic [63:0] nxt_dst;
  frc_fstat_t  fstat_ff;
  frc_fstat_t  nxt_fstat;
  logic [3:0]  cr1_ff;
  logic [3:0]  nxt_cr1;
  frc_op_t     op_ff;
  frc_op_t     nxt_op;
  logic        record_ff;
  logic        nxt_record;
  logic [FRC_IRQ_W-1:0] ist_ff;
  logic [FRC_IRQ_W-1:0] nxt_ist;
  logic [FRC_IRQ_W-1:0] imsk_ff;
  logic [FRC_IRQ_W-1:0] nxt_imsk;
  logic [FRC_IRQ_W-1:0] ev;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pready_ff;
  logic        nxt_pready;
  logic        pslverr_ff;
  logic        nxt_pslverr;
  logic        irq_ff;
  logic        nxt_irq;
  logic        wr_en;
  logic        rd_sel;
  logic        mapped;
  logic [31:0] rd_word;
  logic        start;
  logic        trap;
  frc_res_t    res;

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq     = irq_ff;

  // The datapath is purely combinational on the latched source, so the
  // result settles during the exec cycle and is captured at its end.
  frc_datapath u_datapath (
    .fp_source_reg (src_ff),
    .op            (op_ff),
    .rounding_mode (frc_rm_t'(fstat_ff.rounding_mode_field)),
    .res           (res)
  );

  // Address decode; the access phase takes two cycles so read data and
  // ready both come from flip-flops.
  always_comb begin
    wr_en  = psel && penable && pready_ff && pwrite;
    rd_sel = psel && penable && !pready_ff;
    mapped = 1'b1;
    unique case (paddr)
      FRC_CTRL_OFS:    rd_word = {28'h0, record_ff, op_ff, 1'b0};
      FRC_SRC_LO_OFS:  rd_word = src_ff[31:0];
      FRC_SRC_HI_OFS:  rd_word = src_ff[63:32];
      FRC_FSTAT_OFS:   rd_word = {14'h0, fstat_ff};
      FRC_DST_LO_OFS:  rd_word = dst_ff[31:0];
      FRC_DST_HI_OFS:  rd_word = dst_ff[63:32];
      FRC_CR1_OFS:     rd_word = {28'h0, cr1_ff};
      FRC_IRQ_ST_OFS:  rd_word = {29'h0, ist_ff};
      FRC_IRQ_MSK_OFS: rd_word = {29'h0, imsk_ff};
      FRC_STATUS_OFS:  rd_word = {31'h0, state_ff != FRC_ST_IDLE};
      default: begin
        rd_word = 32'h0;
        mapped  = 1'b0;
      end
    endcase
  end

  // Bus answer: ready rises in the first access cycle's following edge.
  always_comb begin
    nxt_pready  = rd_sel;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = 1'b0;
    if (rd_sel) begin
      nxt_prdata  = pwrite ? 32'h0 : rd_word;
      nxt_pslverr = !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= nxt_pready;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // A start written while an operation runs is ignored.
  assign start = wr_en && (paddr == FRC_CTRL_OFS) && pwdata[FRC_CTRL_START_POS] &&
                 (state_ff == FRC_ST_IDLE);

  // Trap-enabled invalid operation: the destination is left alone.
  assign trap = (res.snan || res.cvt_invalid) && fstat_ff.invalid_op_enable;

  // Sequencing and operand capture.
  always_comb begin
    nxt_state  = state_ff;
    nxt_src    = src_ff;
    nxt_op     = op_ff;
    nxt_record = record_ff;
    if (wr_en && state_ff == FRC_ST_IDLE) begin
      if (paddr == FRC_SRC_LO_OFS) begin
        nxt_src[31:0] = pwdata;
      end
      if (paddr == FRC_SRC_HI_OFS) begin
        nxt_src[63:32] = pwdata;
      end
      if (paddr == FRC_CTRL_OFS) begin
        nxt_op     = frc_op_t'(pwdata[FRC_CTRL_OP_POS +: 2]);
        nxt_record = pwdata[FRC_CTRL_RECORD_POS];
      end
    end
    unique case (state_ff)
      FRC_ST_IDLE: begin
        if (start) begin
          nxt_state = FRC_ST_EXEC;
        end
      end
      FRC_ST_EXEC: nxt_state = FRC_ST_DONE;
      FRC_ST_DONE: nxt_state = FRC_ST_IDLE;
      default:     nxt_state = FRC_ST_IDLE;
    endcase
  end

  // Result, status and condition field update at the end of exec.
  always_comb begin
    nxt_dst   = dst_ff;
    nxt_fstat = fstat_ff;
    nxt_cr1   = cr1_ff;
    if (wr_en && paddr == FRC_FSTAT_OFS && state_ff == FRC_ST_IDLE) begin
      nxt_fstat = frc_fstat_t'(pwdata[17:0]);
    end
    if (state_ff == FRC_ST_EXEC) begin
      if (!trap) begin
        nxt_dst = res.fp_dest_reg;
        // The upper word of a converted result is undefined; it reads as zero here.
      end
      // Convert results leave the class flags as they were.
      if (op_ff == FRC_OP_RSP && !trap) begin
        nxt_fstat.result_class_flags = res.cls;
      end
      nxt_fstat.fraction_rounded_bit = res.rounded;
      nxt_fstat.fraction_inexact_bit = res.inexact;
      nxt_fstat.xx     = fstat_ff.xx | res.inexact;
      nxt_fstat.ox     = fstat_ff.ox | res.ovf;
      nxt_fstat.ux     = fstat_ff.ux | res.unf;
      nxt_fstat.vxsnan = fstat_ff.vxsnan | res.snan;
      nxt_fstat.vxcvi  = fstat_ff.vxcvi | res.cvt_invalid;
      nxt_fstat.vx     = nxt_fstat.vxsnan | nxt_fstat.vxcvi;
      nxt_fstat.fex    = nxt_fstat.vx & fstat_ff.invalid_op_enable;
      nxt_fstat.fx     = fstat_ff.fx | res.snan | res.cvt_invalid | res.ovf | res.unf | res.inexact;
      if (record_ff) begin
        nxt_cr1 = {nxt_fstat.fx, nxt_fstat.fex, nxt_fstat.vx, nxt_fstat.ox};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff  <= FRC_ST_IDLE;
      src_ff    <= FRC_SRC_RST;
      op_ff     <= FRC_OP_RSP;
      record_ff <= 1'b0;
      dst_ff    <= FRC_SRC_RST;
      fstat_ff  <= frc_fstat_t'(FRC_FSTAT_RST);
      cr1_ff    <= FRC_CR1_RST;
    end else begin
      state_ff  <= nxt_state;
      src_ff    <= nxt_src;
      op_ff     <= nxt_op;
      record_ff <= nxt_record;
      dst_ff    <= nxt_dst;
      fstat_ff  <= nxt_fstat;
      cr1_ff    <= nxt_cr1;
    end
  end

  // Events of this cycle; they are only valid at the end of exec.
  always_comb begin
    ev = '0;
    if (state_ff == FRC_ST_EXEC) begin
      ev[FRC_IRQ_DONE_POS]    = 1'b1;
      ev[FRC_IRQ_INVALID_POS] = res.snan | res.cvt_invalid;
      ev[FRC_IRQ_INEXACT_POS] = res.inexact;
    end
  end

  // Sticky status, write one to clear; a new event beats a clear in the same cycle.
  always_comb begin
    nxt_ist  = ist_ff;
    nxt_imsk = imsk_ff;
    if (wr_en && paddr == FRC_IRQ_ST_OFS) begin
      nxt_ist = ist_ff & ~pwdata[FRC_IRQ_W-1:0];
    end
    if (wr_en && paddr == FRC_IRQ_MSK_OFS) begin
      nxt_imsk = pwdata[FRC_IRQ_W-1:0];
    end
    nxt_ist = nxt_ist | ev;
    nxt_irq = |(nxt_ist & nxt_imsk);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_ff  <= '0;
      imsk_ff <= '0;
      irq_ff  <= 1'b0;
    end else begin
      ist_ff  <= nxt_ist;
      imsk_ff <= nxt_imsk;
      irq_ff  <= nxt_irq;
    end
  end

endmodule

// ---- verif/frc_monitor.sv ----
// Concurrent checks on the APB ports of the round and convert slice.
`timescale 1ns/10ps
module frc_monitor
  import frc_pkg::*;
(
  input wire logic        pclk,    // Core clock.
  input wire logic        presetn, // Reset, active low.
  input wire logic        psel,    // APB select.
  input wire logic        penable, // APB enable.
  input wire logic        pwrite,  // APB direction.
  input wire logic [7:0]  paddr,   // APB address.
  input wire logic [31:0] pwdata,  // APB write data.
  input wire logic [31:0] prdata,  // APB read data.
  input wire logic        pready,  // APB ready.
  input wire logic        pslverr, // APB error.
  input wire logic        irq      // Interrupt.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic acc;
  // A completed transfer, the only moment data and errors count.
  assign acc = psel && penable && pready;

  a_ready_two_cycle: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("ready not on second access cycle");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (acc && paddr > 8'h24 |-> pslverr)
    else $error("unmapped address accepted");
  a_mapped_no_err: assert property (acc && paddr <= 8'h24 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped address refused");
  a_unmapped_reads_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_start_reads_zero: assert property (acc && !pwrite && paddr == FRC_CTRL_OFS |-> !prdata[0])
    else $error("start bit reads back");
  a_mask_off_quiet: assert property (acc && pwrite && paddr == FRC_IRQ_MSK_OFS && pwdata[2:0] == 3'h0
                                      |-> ##2 !irq[*3])
    else $error("interrupt while fully masked");

  // Main scenarios seen.
  c_write: cover property (acc && pwrite);
  c_unmapped: cover property (acc && pslverr);
  c_irq: cover property ($rose(irq));
endmodule

// ---- verif/frc_issue_model.sv ----
// APB master standing for the issue logic that feeds the slice.
`timescale 1ns/10ps
module frc_issue_model (
  input wire logic        pclk,    // Core clock.
  output logic            psel,    // APB select.
  output logic            penable, // APB enable.
  output logic            pwrite,  // APB direction.
  output logic [7:0]      paddr,   // APB address.
  output logic [31:0]     pwdata,  // APB write data.
  input wire logic [31:0] prdata,  // APB read data.
  input wire logic        pready,  // APB ready.
  input wire logic        pslverr  // APB error.
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
  end

  // One transfer; it waits for ready however long, the bench timeout ends a hang.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines change so a stale value is never mistaken for a live one.
    paddr <= ~a;
    pwdata <= ~wd;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    logic        er;
    xfer(1'b1, a, wd, rd, er);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic e);
    xfer(1'b0, a, 32'h0, d, e);
  endtask
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the round and convert slice.
`timescale 1ns/10ps
module tb;
  import frc_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  logic        e;
  int          failures = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  frc_issue_model bus (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                       .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  frc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
               .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // The whole run needs under a thousand cycles, so this ceiling only catches a hang.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      failures++;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, x, g);
    end
  endtask

  // Fresh status word, operand, then start; the status write also clears old sticky bits.
  task automatic run(logic [1:0] op, logic [63:0] s, logic [1:0] rm, logic inv_en, logic rec);
    int n;
    bus.wr(FRC_FSTAT_OFS, {29'h0, inv_en, rm});
    bus.wr(FRC_SRC_LO_OFS, s[31:0]);
    bus.wr(FRC_SRC_HI_OFS, s[63:32]);
    bus.wr(FRC_CTRL_OFS, {28'h0, rec, op, 1'b1});
    n = 0;
    do begin
      bus.rd(FRC_STATUS_OFS, d, e);
      n++;
    end while (d[0] !== 1'b0 && n < 20);
    // A slice that never goes idle must count as a mismatch, not pass silently.
    chk("idle", 32'h0, {31'h0, d[0]});
  endtask

  task automatic cls(logic [4:0] x);
    bus.rd(FRC_FSTAT_OFS, d, e);
    chk("class", {27'h0, x}, {27'h0, d[9:5]});
  endtask

  task automatic rsp(logic [63:0] s, logic [1:0] rm, logic [63:0] x, logic [4:0] c);
    run(2'h0, s, rm, 1'b0, 1'b0);
    bus.rd(FRC_DST_LO_OFS, d, e);
    chk("dst_lo", x[31:0], d);
    bus.rd(FRC_DST_HI_OFS, d, e);
    chk("dst_hi", x[63:32], d);
    cls(c);
  endtask

  // Flags are given as {inexact, rounded}.
  task automatic cvt(logic [1:0] op, logic [63:0] s, logic [1:0] rm, logic [31:0] x, logic [1:0] fl);
    run(op, s, rm, 1'b0, 1'b0);
    bus.rd(FRC_DST_LO_OFS, d, e);
    chk("word", x, d);
    bus.rd(FRC_FSTAT_OFS, d, e);
    chk("ix_rnd", {30'h0, fl}, {30'h0, d[4:3]});
    chk("class", 32'h0, {27'h0, d[9:5]});
  endtask

  task automatic sat(logic [1:0] op, logic [63:0] s, logic [31:0] x);
    run(op, s, 2'h0, 1'b0, 1'b0);
    bus.rd(FRC_DST_LO_OFS, d, e);
    chk("sat", x, d);
  endtask

  initial begin
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 36; a += 4) begin
      bus.rd(8'(a), d, e);
      chk("reset", 32'h0, d);
    end
    bus.rd(8'h40, d, e);
    chk("slverr", 32'h1, {31'h0, e});
    $display("test reset and map done");
    rsp(64'h3ff8000000000000, 2'h0, 64'h3ff8000000000000, FRC_CLS_PNORM);
    rsp(64'hbff8000000000000, 2'h2, 64'hbff8000000000000, FRC_CLS_NNORM);
    rsp(64'h3ff0000010000000, 2'h0, 64'h3ff0000000000000, FRC_CLS_PNORM);
    rsp(64'h3ff0000010000000, 2'h1, 64'h3ff0000000000000, FRC_CLS_PNORM);
    rsp(64'h3ff0000010000000, 2'h2, 64'h3ff0000020000000, FRC_CLS_PNORM);
    rsp(64'hbff0000010000000, 2'h3, 64'hbff0000020000000, FRC_CLS_NNORM);
    rsp(64'h0, 2'h0, 64'h0, FRC_CLS_PZERO);
    rsp(64'h47f0000000000000, 2'h0, 64'h7ff0000000000000, FRC_CLS_PINF);
    rsp(64'h47f0000000000000, 2'h1, FRC_SGL_MAXMAG, FRC_CLS_PNORM);
    run(2'h0, 64'h7ff0000000000001, 2'h0, 1'b0, 1'b0);
    cls(FRC_CLS_QNAN);
    run(2'h0, 64'h7ff0000000000001, 2'h0, 1'b1, 1'b0);
    cls(5'h00);
    $display("test round done");
    cvt(2'h1, 64'h4004000000000000, 2'h0, 32'h2, 2'b10);
    cvt(2'h1, 64'h4004000000000000, 2'h1, 32'h2, 2'b10);
    cvt(2'h1, 64'h4004000000000000, 2'h2, 32'h3, 2'b11);
    cvt(2'h1, 64'h4004000000000000, 2'h3, 32'h2, 2'b10);
    cvt(2'h1, 64'h4000000000000000, 2'h2, 32'h2, 2'b00);
    cvt(2'h1, 64'h3fe8000000000000, 2'h0, 32'h1, 2'b11);
    cvt(2'h2, 64'h4004000000000000, 2'h2, 32'h2, 2'b10);
    cvt(2'h2, 64'hc004000000000000, 2'h3, 32'hfffffffe, 2'b10);
    cvt(2'h1, 64'h41dfffffffc00000, 2'h0, FRC_INT_MAXPOS, 2'b00);
    cvt(2'h1, 64'hc1e0000000000000, 2'h0, FRC_INT_MAXNEG, 2'b00);
    sat(2'h1, 64'h41e0000000000000, FRC_INT_MAXPOS);
    sat(2'h2, 64'h41f0000000000000, FRC_INT_MAXPOS);
    sat(2'h1, 64'hc1f0000000000000, FRC_INT_MAXNEG);
    sat(2'h2, 64'hc1f0000000000000, FRC_INT_MAXNEG);
    $display("test convert done");
    bus.rd(FRC_CR1_OFS, d, e);
    chk("cr1", 32'h0, d);
    run(2'h1, 64'h41f0000000000000, 2'h0, 1'b0, 1'b1);
    bus.rd(FRC_CR1_OFS, d, e);
    chk("cr1", 32'ha, d);
    run(2'h0, 64'h3ff8000000000000, 2'h0, 1'b0, 1'b1);
    bus.rd(FRC_CR1_OFS, d, e);
    chk("cr1", 32'h0, d);
    $display("test record done");
    bus.wr(FRC_IRQ_ST_OFS, 32'h7);
    bus.wr(FRC_IRQ_MSK_OFS, 32'h1);
    run(2'h0, 64'h3ff8000000000000, 2'h0, 1'b0, 1'b0);
    chk("irq", 32'h1, {31'h0, irq});
    bus.rd(FRC_IRQ_ST_OFS, d, e);
    chk("irq_st", 32'h1, d);
    bus.wr(FRC_IRQ_ST_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    bus.wr(FRC_IRQ_MSK_OFS, 32'h0);
    run(2'h0, 64'h3ff8000000000000, 2'h0, 1'b0, 1'b0);
    chk("irq", 32'h0, {31'h0, irq});
    bus.rd(FRC_IRQ_ST_OFS, d, e);
    chk("irq_st", 32'h1, d);
    $display("test interrupt done");
    results();
  end
endmodule

bind frc_top frc_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                              .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
                              .pslverr(pslverr), .irq(irq));
